//--- hw/hed_defs.svh
/*
 constants for the dual bus ecc unit: register offsets, field positions,
 reset values and buffer depths. assumes an axi4-lite master with 32-bit data.
*/
// Overview of operation
// - hamming code, 8 check bits, fix single
// - read and write buffers hold sixteen words, or eight when dual8 is set
// - syndrome latch, saturating counter, error word latch
// - system byte driven only when enabled
// - system input latch transparent high, holds
// - system output from memory latch or buffer
// - memory input latch captures data and checks
// - memory output latch captures mux and code
// - memory drive enables data and check outputs
// - code or syndrome output selected by pick
// - lane select picks memory or system byte
// - lane selects buffered with each written word
// - byte parity generated, checked, sense selectable
// - memory path takes buffer or input latch
// - system clock pushes system word to buffer
// - memory clock pushes corrected word to buffer
// - system clock pop advances read buffer
// - empty flag low at last word, blocks
// - full flag after 16 or 8 writes
// - half flag low at eight or four
// - fault flags unlatched, updated each enabled clock
`ifndef HED_DEFS_SVH
`define HED_DEFS_SVH
// register byte offsets
`define HED_CTRL_OFF 4'h0
`define HED_DIAG_OFF 4'h4
`define HED_ERRLO_OFF 4'h8
`define HED_ERRHI_OFF 4'hc
// control register fields
`define HED_CTRL_ODD_BIT 0
`define HED_CTRL_CLR_BIT 1
`define HED_CTRL_RESET 1'b0
// diag register fields
`define HED_DIAG_CNT_LSB 8
`define HED_CNT_MAX 4'hf
// buffer depths
`define HED_DEPTH_FULL 5'h10
`define HED_DEPTH_DUAL 5'h08
`define HED_HALF_FULL 5'h08
`define HED_HALF_DUAL 5'h04
// number of hamming positions used
`define HED_POS_LIMIT 72
// synchronised control idle value
`define HED_CTL_IDLE 23'h618c00
// axi responses
`define HED_RESP_OK 2'h0
`define HED_RESP_ERR 2'h2
`endif

//--- hw/hed_ecc.sv
/*
 dual bus ecc unit: sec-ded over 64-bit words, read and write buffers,
 byte parity, diagnostics over axi4-lite.
 assumes data pins are stable while their strobes pass the synchroniser,
 and that the memory clock pin runs well below half of CLK.
*/
`timescale 1ns/1ns
`include "hed_defs.svh"

module hed_fifo
   import hed_pkg::*;
#(
   parameter int W = 72
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // configuration
   input wire logic clr,
   input wire logic dual8,
   // requests
   input wire logic push,
   input wire logic pop,
   input wire logic [W-1:0] din,
   // head and fill
   output logic [W-1:0] dout,
   output logic [4:0] cnt
);
   logic [W-1:0] mem [16]; // storage
   logic [3:0] wp_reg; // write pointer
   logic [3:0] rp_reg; // read pointer
   logic [4:0] n_reg; // words held
   logic [4:0] cap; // depth in use
   logic [3:0] last; // last pointer value
   logic do_push; // accepted write
   logic do_pop; // accepted read

   assign cap = dual8 ? `HED_DEPTH_DUAL : `HED_DEPTH_FULL;
   assign last = 4'(cap - 5'h01);
   assign do_push = push && (n_reg != cap);
   assign do_pop = pop && (n_reg > 5'h01);
   assign dout = mem[rp_reg];
   assign cnt = n_reg;

   // pointers and fill count
   always_ff @(posedge clk)
   begin
      if (!rstn || clr)
      begin
         wp_reg <= 4'h0;
         rp_reg <= 4'h0;
         n_reg <= 5'h00;
      end
      else if (ce)
      begin
         if (do_push)
            wp_reg <= (wp_reg == last) ? 4'h0 : wp_reg + 4'h1;
         if (do_pop)
            rp_reg <= (rp_reg == last) ? 4'h0 : rp_reg + 4'h1;
         n_reg <= n_reg + {4'h0, do_push} - {4'h0, do_pop};
      end
   end

   // storage write
   always_ff @(posedge clk)
   begin
      if (ce && do_push)
         mem[wp_reg] <= din;
   end
endmodule // hed_fifo

module hed_ecc
   import hed_pkg::*;
(
   // clock, reset, enable
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   // system data bus
   input wire logic [63:0] SD_I,
   output logic [63:0] SD_O,
   output logic [7:0] SD_OE,
   // memory data and check bits
   input wire logic [63:0] MD_I,
   output logic [63:0] MD_O,
   output logic MD_OE,
   input wire logic [7:0] CHECK_BITS_IN,
   output logic [7:0] CHECK_BITS_OUT,
   output logic CHECK_BITS_OE,
   output logic [7:0] CODE_OR_SYNDROME_OUT,
   // byte parity lines
   input wire logic [7:0] BYTE_ODD_EVEN_LINES_I,
   output logic [7:0] BYTE_ODD_EVEN_LINES_O,
   output logic [7:0] BYTE_ODD_EVEN_LINES_OE,
   // control pins
   input wire logic SYSTEM_DRIVE_N,
   input wire logic [7:0] LANE_SELECT,
   input wire logic MEMORY_DRIVE_N,
   input wire logic MEMORY_IN_CAPTURE,
   input wire logic MEMORY_OUT_CAPTURE,
   input wire logic MEMORY_SRC_PICK,
   input wire logic SYSTEM_IN_CAPTURE,
   input wire logic WQ_PUSH_N,
   input wire logic WQ_OUT_EN_N,
   input wire logic [1:0] FIFO_CONFIG_RESET,
   input wire logic SYSTEM_SRC_PICK,
   input wire logic RQ_PUSH_N,
   input wire logic RQ_POP_N,
   input wire logic CODE_OR_SYNDROME_PICK,
   input wire logic MEMORY_CLOCK,
   // status pins
   output logic WQ_EMPTY_N,
   output logic WQ_FULL_N,
   output logic RQ_EMPTY_N,
   output logic RQ_HALF_N,
   output logic RQ_FULL_N,
   output logic FAULT_FLAG_N,
   output logic MULTI_FAULT_FLAG_N,
   output logic BYTE_CHECK_FAULT_N,
   // axi4-lite slave
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   // hamming position of data bit i, skipping powers of two
   function automatic logic [6:0] pos_of(input int i);
      int n;
      logic [6:0] r;
      n = 0;
      r = 7'h00;
      for (int p = 3; p < `HED_POS_LIMIT; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (n == i)
               r = 7'(p);
            n++;
         end
      end
      return r;
   endfunction

   // check bits of a word, bit 7 is overall parity
   function automatic logic [7:0] code_of(input logic [63:0] d);
      logic [7:0] c;
      logic [6:0] p;
      c = 8'h00;
      for (int i = 0; i < 64; i++)
      begin
         p = pos_of(i);
         for (int k = 0; k < 7; k++)
            if (p[k])
               c[k] = c[k] ^ d[i];
      end
      c[7] = (^d) ^ (^c[6:0]);
      return c;
   endfunction

   hed_ctl_t raw; // control pins as a vector
   hed_ctl_t s1_reg; // first synchroniser stage
   hed_ctl_t s2_reg; // second stage
   hed_ctl_t s3_reg; // third stage
   hed_ctl_t f_reg; // filtered level
   hed_ctl_t fq_reg; // filtered level, one cycle late
   logic [63:0] sd_in_reg; // system input latch
   logic [63:0] md_in_reg; // memory input latch, data
   logic [7:0] cb_in_reg; // memory input latch, checks
   logic [63:0] mo_data_reg; // memory output latch, data
   logic [7:0] mo_chk_reg; // memory output latch, checks
   logic [7:0] syn; // syndrome of memory latch
   logic [7:0] md_code; // check bits regenerated from memory latch
   logic single; // one bit in error
   logic multi; // uncorrectable error
   logic [63:0] flip; // bit to invert
   logic [63:0] md_cor; // corrected memory word
   logic [63:0] mux_src; // system side source
   logic [7:0] be_eff; // lane selects for mux
   logic [63:0] mux_out; // byte mux output
   logic [71:0] wq_head; // write buffer head
   logic [63:0] rq_head; // read buffer head
   logic [4:0] wq_cnt; // write buffer fill
   logic [4:0] rq_cnt; // read buffer fill
   logic fifo_clr; // buffers held in reset
   logic dual8_reg; // dual 8-deep configuration
   logic mclk_rise; // memory clock rising edge
   logic mic_fall; // memory capture falling edge
   logic [63:0] sd_out_reg; // system output data
   logic [7:0] par_out_reg; // generated parity
   logic pfault_n_reg; // parity fault
   logic fault_n_reg; // error flag
   logic mfault_n_reg; // multiple error flag
   logic [7:0] cs_reg; // code or syndrome output
   logic odd_reg; // parity sense, 1 = odd
   logic clr_reg; // diag clear pulse
   logic [7:0] diag_syn_reg; // syndrome latch
   logic [3:0] diag_cnt_reg; // error counter
   logic [63:0] diag_word_reg; // error data latch
   logic aw_hold_reg; // write address held
   logic w_hold_reg; // write data held
   logic [3:0] aw_addr_reg; // held write address
   logic [31:0] w_data_reg; // held write data
   logic w_strb0_reg; // held low byte strobe
   logic bvalid_reg; // write response pending
   logic [1:0] bresp_reg; // write response code
   logic rvalid_reg; // read data pending
   logic [1:0] rresp_reg; // read response code
   logic [31:0] rdata_reg; // read data

   assign raw = {SYSTEM_DRIVE_N, MEMORY_DRIVE_N, MEMORY_IN_CAPTURE,
      MEMORY_OUT_CAPTURE, MEMORY_SRC_PICK, SYSTEM_IN_CAPTURE, WQ_PUSH_N,
      WQ_OUT_EN_N, FIFO_CONFIG_RESET, SYSTEM_SRC_PICK, RQ_PUSH_N, RQ_POP_N,
      CODE_OR_SYNDROME_PICK, MEMORY_CLOCK, LANE_SELECT};

   // three stage synchroniser; level moves once stages two and three agree
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         s1_reg <= `HED_CTL_IDLE;
         s2_reg <= `HED_CTL_IDLE;
         s3_reg <= `HED_CTL_IDLE;
         f_reg <= `HED_CTL_IDLE;
         fq_reg <= `HED_CTL_IDLE;
      end
      else if (CE)
      begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         f_reg <= (f_reg & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
         fq_reg <= f_reg;
      end
   end

   assign mclk_rise = f_reg.mem_clk && !fq_reg.mem_clk;
   assign mic_fall = !f_reg.mem_in_cap && fq_reg.mem_in_cap;
   assign fifo_clr = !f_reg.cfg_rst[1];

   // depth is taken while the buffers are held in reset
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         dual8_reg <= 1'b0;
      else if (CE && fifo_clr)
         dual8_reg <= f_reg.cfg_rst[0];
   end

   // input latches: follow while open, hold once closed
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         sd_in_reg <= 64'h0;
         md_in_reg <= 64'h0;
         cb_in_reg <= 8'h00;
      end
      else if (CE)
      begin
         if (f_reg.sys_in_cap)
            sd_in_reg <= SD_I;
         if (f_reg.mem_in_cap)
         begin
            md_in_reg <= MD_I;
            cb_in_reg <= CHECK_BITS_IN;
         end
      end
   end

   // syndrome and error class
   always_comb
   begin
      md_code = code_of(md_in_reg);
      syn[6:0] = cb_in_reg[6:0] ^ md_code[6:0];
      syn[7] = (^md_in_reg) ^ (^cb_in_reg);
      single = syn[7] && (syn[6:0] < 7'(`HED_POS_LIMIT));
      multi = (syn != 8'h00) && !single;
   end

   // per bit correction and byte mux
   for (genvar g = 0; g < 64; g++)
   begin : g_bit
      assign flip[g] = single && (syn[6:0] == pos_of(g));
      assign md_cor[g] = md_in_reg[g] ^ flip[g];
      assign mux_out[g] = be_eff[g / 8] ? md_cor[g] : mux_src[g];
   end

   assign mux_src = f_reg.mem_src_pick ? wq_head[63:0] : sd_in_reg;
   assign be_eff = f_reg.mem_src_pick ? wq_head[71:64] : f_reg.lane;

   // write buffer keeps lane selects beside each word
   hed_fifo #(.W(72)) u_wq (
      .clk(CLK),
      .rstn(RSTN),
      .ce(CE),
      .clr(fifo_clr),
      .dual8(dual8_reg),
      .push(!f_reg.wq_push_n),
      .pop(!f_reg.wq_out_en_n),
      .din({f_reg.lane, SD_I}),
      .dout(wq_head),
      .cnt(wq_cnt)
   );

   // read buffer filled on rising memory clock edges
   hed_fifo #(.W(64)) u_rq (
      .clk(CLK),
      .rstn(RSTN),
      .ce(CE),
      .clr(fifo_clr),
      .dual8(dual8_reg),
      .push(mclk_rise && !f_reg.rq_push_n),
      .pop(!f_reg.rq_pop_n),
      .din(md_cor),
      .dout(rq_head),
      .cnt(rq_cnt)
   );

   // buffer flags, all active low
   assign WQ_EMPTY_N = wq_cnt > 5'h01;
   assign RQ_EMPTY_N = rq_cnt > 5'h01;
   assign WQ_FULL_N = wq_cnt != (dual8_reg ? `HED_DEPTH_DUAL : `HED_DEPTH_FULL);
   assign RQ_FULL_N = rq_cnt != (dual8_reg ? `HED_DEPTH_DUAL : `HED_DEPTH_FULL);
   assign RQ_HALF_N = rq_cnt < (dual8_reg ? `HED_HALF_DUAL : `HED_HALF_FULL);

   // memory output latch, open while capture is low
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         mo_data_reg <= 64'h0;
         mo_chk_reg <= 8'h00;
      end
      else if (CE && !f_reg.mem_out_cap)
      begin
         mo_data_reg <= mux_out;
         mo_chk_reg <= code_of(mux_out);
      end
   end

   assign MD_O = mo_data_reg;
   assign CHECK_BITS_OUT = mo_chk_reg;
   assign MD_OE = !f_reg.mem_drive_n;
   assign CHECK_BITS_OE = !f_reg.mem_drive_n;
   assign CODE_OR_SYNDROME_OUT = cs_reg;

   // system side outputs, parity and flags
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         sd_out_reg <= 64'h0;
         par_out_reg <= 8'h00;
         pfault_n_reg <= 1'b1;
         fault_n_reg <= 1'b1;
         mfault_n_reg <= 1'b1;
         cs_reg <= 8'h00;
      end
      else if (CE)
      begin
         sd_out_reg <= f_reg.sys_src_pick ? rq_head : md_cor;
         for (int b = 0; b < 8; b++)
            par_out_reg[b] <= (^sd_out_reg[8*b +: 8]) ^ odd_reg;
         pfault_n_reg <= 1'b1;
         for (int b = 0; b < 8; b++)
            if (!f_reg.lane[b] && (BYTE_ODD_EVEN_LINES_I[b] !=
               ((^sd_in_reg[8*b +: 8]) ^ odd_reg)))
               pfault_n_reg <= 1'b0;
         fault_n_reg <= syn == 8'h00;
         mfault_n_reg <= !multi;
         cs_reg <= f_reg.cs_pick ? mo_chk_reg : syn;
      end
   end

   assign SD_O = sd_out_reg;
   assign SD_OE = f_reg.sys_drive_n ? 8'h00 : f_reg.lane;
   assign BYTE_ODD_EVEN_LINES_O = par_out_reg;
   assign BYTE_ODD_EVEN_LINES_OE = f_reg.sys_drive_n ? 8'h00 : f_reg.lane;
   assign BYTE_CHECK_FAULT_N = pfault_n_reg;
   assign FAULT_FLAG_N = fault_n_reg;
   assign MULTI_FAULT_FLAG_N = mfault_n_reg;

   // diagnostics: an error at memory capture wins over a clear
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         diag_syn_reg <= 8'h00;
         diag_cnt_reg <= 4'h0;
         diag_word_reg <= 64'h0;
      end
      else if (CE)
      begin
         if (mic_fall && syn != 8'h00)
         begin
            diag_syn_reg <= syn;
            diag_word_reg <= md_in_reg;
            if (clr_reg)
               diag_cnt_reg <= 4'h1;
            else if (diag_cnt_reg != `HED_CNT_MAX)
               diag_cnt_reg <= diag_cnt_reg + 4'h1;
         end
         else if (clr_reg)
         begin
            diag_syn_reg <= 8'h00;
            diag_cnt_reg <= 4'h0;
            diag_word_reg <= 64'h0;
         end
      end
   end

   // axi write channels, taken in either order
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg <= 32'h0;
         w_strb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `HED_RESP_OK;
      end
      else if (CE)
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb0_reg <= S_AXI_WSTRB[0];
         end
         if (aw_hold_reg && w_hold_reg && !bvalid_reg)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (aw_addr_reg[3:2] == `HED_CTRL_OFF >> 2 ||
               aw_addr_reg[3:2] == `HED_DIAG_OFF >> 2) ? `HED_RESP_OK : `HED_RESP_ERR;
         end
         else if (bvalid_reg && S_AXI_BREADY)
            bvalid_reg <= 1'b0;
      end
   end

   assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
   assign S_AXI_WREADY = !w_hold_reg && !bvalid_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;

   // control register: parity sense and diag clear pulse
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         odd_reg <= `HED_CTRL_RESET;
         clr_reg <= 1'b0;
      end
      else if (CE)
      begin
         clr_reg <= 1'b0;
         if (aw_hold_reg && w_hold_reg && !bvalid_reg && w_strb0_reg &&
            aw_addr_reg[3:2] == `HED_CTRL_OFF >> 2)
         begin
            odd_reg <= w_data_reg[`HED_CTRL_ODD_BIT];
            clr_reg <= w_data_reg[`HED_CTRL_CLR_BIT];
         end
      end
   end

   // axi read channel
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg <= `HED_RESP_OK;
         rdata_reg <= 32'h0;
      end
      else if (CE)
      begin
         if (S_AXI_ARVALID && S_AXI_ARREADY)
         begin
            rvalid_reg <= 1'b1;
            rresp_reg <= `HED_RESP_OK;
            case (S_AXI_ARADDR)
               `HED_CTRL_OFF: rdata_reg <= {31'h0, odd_reg};
               `HED_DIAG_OFF: rdata_reg <= {20'h0, diag_cnt_reg, diag_syn_reg};
               `HED_ERRLO_OFF: rdata_reg <= diag_word_reg[31:0];
               `HED_ERRHI_OFF: rdata_reg <= diag_word_reg[63:32];
               default:
               begin
                  rdata_reg <= 32'h0;
                  rresp_reg <= `HED_RESP_ERR;
               end
            endcase
         end
         else if (rvalid_reg && S_AXI_RREADY)
            rvalid_reg <= 1'b0;
      end
   end

   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;
endmodule // hed_ecc

//--- hw/hed_pkg.sv
/*
 types for the dual bus ecc unit.
 assumes hed_defs.svh supplies the numbers.
*/
package hed_pkg;
   // synchronised control pins, one field each
   typedef struct packed {
      logic sys_drive_n;
      logic mem_drive_n;
      logic mem_in_cap;
      logic mem_out_cap;
      logic mem_src_pick;
      logic sys_in_cap;
      logic wq_push_n;
      logic wq_out_en_n;
      logic [1:0] cfg_rst;
      logic sys_src_pick;
      logic rq_push_n;
      logic rq_pop_n;
      logic cs_pick;
      logic mem_clk;
      logic [7:0] lane;
   } hed_ctl_t;
endpackage

//--- testbench/hed_ecc_asserts.sv
/*
 checker for the ecc unit pins.
 assumes control pins reach the logic within five clocks.
*/
`timescale 1ns/1ns
module hed_ecc_asserts
(
   // clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // drive controls
   input wire logic SYSTEM_DRIVE_N,
   input wire logic [7:0] LANE_SELECT,
   input wire logic MEMORY_DRIVE_N,
   input wire logic WQ_PUSH_N,
   input wire logic WQ_OUT_EN_N,
   input wire logic [1:0] FIFO_CONFIG_RESET,
   // enables
   input wire logic [7:0] SD_OE,
   input wire logic [7:0] BYTE_ODD_EVEN_LINES_OE,
   input wire logic MD_OE,
   input wire logic CHECK_BITS_OE,
   // flags
   input wire logic WQ_EMPTY_N,
   input wire logic WQ_FULL_N,
   input wire logic RQ_EMPTY_N,
   input wire logic RQ_HALF_N,
   input wire logic RQ_FULL_N,
   input wire logic FAULT_FLAG_N,
   input wire logic MULTI_FAULT_FLAG_N
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // steady push with nothing popping
   sequence s_wq_fill;
      (!WQ_PUSH_N && WQ_OUT_EN_N && FIFO_CONFIG_RESET[1]) [*8];
   endsequence
   oe_pair_a: assert property (MD_OE == CHECK_BITS_OE)
      else $error("memory enables differ");
   mem_on_a: assert property (!MEMORY_DRIVE_N [*6] |-> MD_OE)
      else $error("memory bus not driven");
   mem_off_a: assert property (MEMORY_DRIVE_N [*6] |-> !MD_OE)
      else $error("memory bus driven");
   sys_off_a: assert property (SYSTEM_DRIVE_N [*6] |-> SD_OE == 8'h00)
      else $error("system bus driven");
   sys_on_a: assert property ((!SYSTEM_DRIVE_N && $stable(LANE_SELECT)) [*6]
      |-> SD_OE == LANE_SELECT)
      else $error("system lanes not driven");
   par_oe_a: assert property (BYTE_ODD_EVEN_LINES_OE == SD_OE)
      else $error("parity enable differs");
   wq_full_a: assert property (!WQ_FULL_N |-> WQ_EMPTY_N)
      else $error("full and empty together");
   rq_half_a: assert property (!RQ_HALF_N |-> RQ_EMPTY_N)
      else $error("half with empty");
   rq_full_a: assert property (!RQ_FULL_N |-> !RQ_HALF_N)
      else $error("full without half");
   fault_pair_a: assert property (!MULTI_FAULT_FLAG_N |-> !FAULT_FLAG_N)
      else $error("multi without fault");
   reset_flags_a: assert property ($rose(RSTN) |-> !WQ_EMPTY_N && !RQ_EMPTY_N
      && WQ_FULL_N && RQ_FULL_N)
      else $error("flags after reset");
   wq_fill_a: assert property (s_wq_fill |-> WQ_EMPTY_N)
      else $error("push not stored");
endmodule // hed_ecc_asserts

bind hed_ecc hed_ecc_asserts chk_u (.*);

//--- testbench/hed_ecc_tb_top.sv
/*
 testbench for the ecc unit: memory round trips, diagnostics, buffers.
 assumes control pins settle within six clocks.
*/
`timescale 1ns/1ns
module hed_ecc_tb_top;
   localparam logic [63:0] D = 64'h0123456789abcdef;
   logic CLK, RSTN, CE, SYSTEM_DRIVE_N, MEMORY_DRIVE_N, MEMORY_IN_CAPTURE;
   logic MEMORY_OUT_CAPTURE, MEMORY_SRC_PICK, SYSTEM_IN_CAPTURE, WQ_PUSH_N;
   logic WQ_OUT_EN_N, SYSTEM_SRC_PICK, RQ_PUSH_N, RQ_POP_N, CODE_OR_SYNDROME_PICK;
   logic MEMORY_CLOCK, MD_OE, CHECK_BITS_OE, WQ_EMPTY_N, WQ_FULL_N, RQ_EMPTY_N;
   logic RQ_HALF_N, RQ_FULL_N, FAULT_FLAG_N, MULTI_FAULT_FLAG_N, BYTE_CHECK_FAULT_N;
   logic [63:0] SD_I, SD_O, MD_I, MD_O;
   logic [7:0] SD_OE, CHECK_BITS_IN, CHECK_BITS_OUT, CODE_OR_SYNDROME_OUT, LANE_SELECT;
   logic [7:0] BYTE_ODD_EVEN_LINES_I, BYTE_ODD_EVEN_LINES_O, BYTE_ODD_EVEN_LINES_OE;
   logic [1:0] FIFO_CONFIG_RESET, S_AXI_BRESP, S_AXI_RRESP, b;
   logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, r;
   logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
   logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic mwr, mrd;
   logic [71:0] flip;
   logic [71:0] flips [4] = '{72'h0, 72'h20, 72'h8000000000000000, 72'h3};
   int fails = 0;
   int n_tests = 0;
   hed_ecc dut_u (.*);
   hed_mem_model mem_u (.clk(CLK), .wr(mwr), .rd(mrd), .flip(flip), .md_in(MD_O),
      .cb_in(CHECK_BITS_OUT), .md_out(MD_I), .cb_out(CHECK_BITS_IN));
   initial
   begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   // memory clock, four system clocks per phase
   initial
   begin
      MEMORY_CLOCK = 1'b0;
      forever
      begin
         repeat (4) @(posedge CLK);
         MEMORY_CLOCK <= ~MEMORY_CLOCK;
      end
   end
   task w(input int n);
      repeat (n) @(posedge CLK);
   endtask
   task chk(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task finish_test;
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // register write, both channels offered together
   task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do
      begin
         @(posedge CLK);
         if (S_AXI_AWREADY)
            S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY)
            S_AXI_WVALID <= 1'b0;
      end
      while (!S_AXI_BVALID);
      rs = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do
      begin
         @(posedge CLK);
         if (S_AXI_ARREADY)
            S_AXI_ARVALID <= 1'b0;
      end
      while (!S_AXI_RVALID);
      d = S_AXI_RDATA;
      S_AXI_RREADY <= 1'b0;
   endtask
   // memory read pass with an error mask, latch closes after six of twelve clocks
   task cap(input logic [71:0] f);
      flip <= f;
      mrd <= 1'b1;
      MEMORY_IN_CAPTURE <= 1'b1;
      w(6);
      MEMORY_IN_CAPTURE <= 1'b0;
      w(6);
   endtask
   // odd parity of each byte
   function logic [7:0] par(input logic [63:0] v);
      for (int k = 0; k < 8; k++)
         par[k] = ~^v[8*k+:8];
   endfunction
   initial
   begin
      repeat (5000) @(posedge CLK);
      fails++;
      finish_test;
   end
   initial
   begin
      {RSTN, SYSTEM_IN_CAPTURE, CE, SYSTEM_DRIVE_N, MEMORY_DRIVE_N} = 5'h0f;
      {MEMORY_IN_CAPTURE, MEMORY_OUT_CAPTURE, MEMORY_SRC_PICK, SYSTEM_SRC_PICK} = 4'h0;
      {WQ_PUSH_N, WQ_OUT_EN_N, RQ_PUSH_N, RQ_POP_N} = 4'hf;
      {CODE_OR_SYNDROME_PICK, mwr, mrd} = 3'h0;
      {SD_I, LANE_SELECT, BYTE_ODD_EVEN_LINES_I, flip, FIFO_CONFIG_RESET} = '0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID} = '0;
      {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 3'h0;
      S_AXI_WSTRB = 4'hf;
      w(6);
      RSTN <= 1'b1;
      FIFO_CONFIG_RESET <= 2'b10;
      SD_I <= D;
      w(6);
      chk(WQ_EMPTY_N, 1'b0);
      // latch closes, later bus changes must not reach memory
      SYSTEM_IN_CAPTURE <= 1'b0;
      w(6);
      SD_I <= ~D;
      MEMORY_OUT_CAPTURE <= 1'b1;
      MEMORY_DRIVE_N <= 1'b0;
      w(6);
      chk(MD_O, D);
      mwr <= 1'b1;
      w(1);
      mwr <= 1'b0;
      MEMORY_DRIVE_N <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         cap(flips[i]);
         chk(FAULT_FLAG_N, i == 0);
         chk(MULTI_FAULT_FLAG_N, i < 3);
         chk(CODE_OR_SYNDROME_OUT[7], i == 1 || i == 2);
         if (i < 3)
            chk(SD_O, D);
      end
      repeat (13) cap(72'h1);
      rd(4'h4, r);
      chk(r[11:8], 4'hf);
      rd(4'h8, r);
      chk(r, D[31:0] ^ 32'h1);
      wr(4'h0, 32'h3, b);
      rd(4'h4, r);
      chk(r[11:8], 4'h0);
      rd(4'h0, r);
      chk(r, 32'h1);
      wr(4'h8, 32'h0, b);
      chk(b, 2'h2);
      cap(72'h0);
      CODE_OR_SYNDROME_PICK <= 1'b1;
      w(6);
      chk(CODE_OR_SYNDROME_OUT, CHECK_BITS_IN);
      CODE_OR_SYNDROME_PICK <= 1'b0;
      SYSTEM_DRIVE_N <= 1'b0;
      LANE_SELECT <= 8'h0f;
      BYTE_ODD_EVEN_LINES_I <= par(D);
      w(6);
      chk(SD_OE, 8'h0f);
      chk(BYTE_ODD_EVEN_LINES_O, par(D));
      chk(BYTE_CHECK_FAULT_N, 1'b1);
      BYTE_ODD_EVEN_LINES_I <= par(D) ^ 8'h80;
      w(6);
      chk(BYTE_CHECK_FAULT_N, 1'b0);
      SYSTEM_DRIVE_N <= 1'b1;
      LANE_SELECT <= 8'h00;
      WQ_PUSH_N <= 1'b0;
      w(24);
      WQ_PUSH_N <= 1'b1;
      w(6);
      chk(WQ_FULL_N, 1'b0);
      MEMORY_SRC_PICK <= 1'b1;
      MEMORY_OUT_CAPTURE <= 1'b0;
      w(6);
      chk(MD_O, ~D);
      WQ_OUT_EN_N <= 1'b0;
      w(24);
      WQ_OUT_EN_N <= 1'b1;
      w(6);
      chk(WQ_EMPTY_N, 1'b0);
      FIFO_CONFIG_RESET <= 2'b01;
      w(6);
      FIFO_CONFIG_RESET <= 2'b11;
      RQ_PUSH_N <= 1'b0;
      w(100);
      RQ_PUSH_N <= 1'b1;
      SYSTEM_SRC_PICK <= 1'b1;
      w(6);
      chk(RQ_FULL_N, 1'b0);
      chk(RQ_HALF_N, 1'b0);
      chk(SD_O, D);
      CE <= 1'b0;
      RQ_POP_N <= 1'b0;
      w(10);
      chk(RQ_FULL_N, 1'b0);
      CE <= 1'b1;
      w(20);
      RQ_POP_N <= 1'b1;
      w(6);
      chk(RQ_HALF_N, 1'b1);
      chk(RQ_EMPTY_N, 1'b0);
      finish_test;
   end
endmodule // hed_ecc_tb_top

//--- testbench/hed_mem_model.sv
/*
 memory array with check-bit storage, one word deep.
 assumes the bench strobes wr only while the unit drives memory.
*/
`timescale 1ns/1ns
module hed_mem_model
(
   // clock and strobes
   input wire logic clk,
   input wire logic wr,
   input wire logic rd,
   // error mask, check bits on top
   input wire logic [71:0] flip,
   // unit side
   input wire logic [63:0] md_in,
   input wire logic [7:0] cb_in,
   output logic [63:0] md_out,
   output logic [7:0] cb_out
);
   // stored word and last value put on the bus
   logic [71:0] word_reg = 72'h0;
   logic [71:0] last_reg = 72'h0;
   // store on write strobe, note what was driven
   always_ff @(posedge clk)
   begin
      if (wr)
         word_reg <= {cb_in, md_in};
      if (rd)
         last_reg <= word_reg ^ flip;
   end
   // released bus shows the inverse, not a stale copy
   assign {cb_out, md_out} = rd ? word_reg ^ flip : ~last_reg;
endmodule // hed_mem_model
